// File: ersr_pair_buffer.sv
`timescale 1ns/1ps
`default_nettype none

module ersr_pair_buffer #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);

    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
        logic ready;
    } ersr_buf_state_t;

    ersr_buf_state_t st_reg;
    ersr_buf_state_t st_next;

    // push and pop; ready is recomputed from the next fill level
    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        st_next = st_reg;
        push = i_in_valid && st_reg.ready;
        pop = i_out_ready && (st_reg.count != '0);
        if (push) begin
            st_next.mem[st_reg.wr_ptr] = i_in_data;
            st_next.wr_ptr = (st_reg.wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.rd_ptr = (st_reg.rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (pop && !push) begin
            st_next.count = st_reg.count - 1'b1;
        end
        st_next.ready = (st_next.count != CNT_W'(DEPTH));
    end

    // state register
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
            st_reg.ready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_in_ready = st_reg.ready;
    assign o_out_valid = (st_reg.count != '0);
    assign o_out_data = st_reg.mem[st_reg.rd_ptr];

endmodule

`default_nettype wire

// File: ersr_pkg.sv
package ersr_pkg;

    // system clock and time base
    localparam int CLOCK_KHZ = 25000;
    localparam int SECOND_MS = 1000;
    localparam int ERR_HOLDOFF_MS = 128;
    localparam int MARK_HIGH_MS = 8;
    localparam int CRC_TIMEOUT_MS = 8;
    localparam int SECOND_CYCLES = SECOND_MS * CLOCK_KHZ;
    localparam int ERR_HOLDOFF_CYCLES = ERR_HOLDOFF_MS * CLOCK_KHZ;
    localparam int MARK_HIGH_CYCLES = MARK_HIGH_MS * CLOCK_KHZ;
    localparam int CRC_TIMEOUT_CYCLES = CRC_TIMEOUT_MS * CLOCK_KHZ;
    localparam int TIMER_W = 25;

    // frame alignment error counting
    localparam int ERR_CNT_W = 5;
    localparam logic [4:0] ERR_THRESHOLD = 5'h10;

    // output stream slots (channel numbers on the control/status stream)
    localparam logic [4:0] CH_ALIGN_WORD = 5'h10;
    localparam logic [4:0] CH_NONALIGN_WORD = 5'h11;
    localparam logic [4:0] CH_MASTER_ONE = 5'h12;
    localparam logic [4:0] CH_PHASE_WORD = 5'h13;
    localparam logic [4:0] CH_CRC_COUNT = 5'h14;
    localparam logic [4:0] CH_MASTER_TWO = 5'h15;

    // frame position counter: channel in [7:3], bit in [2:0]
    localparam int FRAME_POS_W = 8;
    localparam int CHAN_MSB = 7;
    localparam int CHAN_LSB = 3;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [7:0] FRAME_POS_FIRST = 8'h00;
    // channels 16 and 17 share this upper nibble of the frame position
    localparam logic [3:0] TS0_WINDOW_NIBBLE = 4'h8;

    // phase word wrap points
    localparam logic [7:0] PHASE_TOP = 8'hFF;
    localparam logic [7:0] PHASE_BOTTOM = 8'h00;

    // reset values
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] ALIGN_IDLE = 8'hFF;
    localparam logic UNUSED_BIT = 1'b0;

    // timeslot 0 word carried through the buffer: {is_align_frame, byte}
    localparam int TS0_W = 9;
    localparam int TS0_KIND_BIT = 8;

endpackage

// File: ersr_status_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ersr_status_checker (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_backplane_bit_clock,
    input wire logic i_backplane_frame_n,
    input wire logic i_ts0_valid,
    input wire logic o_ts0_ready,
    input wire logic o_control_status_out_stream,
    input wire logic o_control_status_out_enable
);
    localparam int HI_MIN = 580;
    localparam int HI_MAX = 592;
    localparam int LO_MIN = 2530;
    localparam int LO_MAX = 2546;
    logic bclk_reg;
    logic [7:0] fall_reg;
    logic [11:0] hi_reg;
    logic [11:0] lo_reg;
    logic [1:0] seen_reg;

    // raw bit clock falls and the run lengths of the slot enable
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            bclk_reg <= 1'b1;
            fall_reg <= 8'h00;
            hi_reg <= 12'h000;
            lo_reg <= 12'h000;
            seen_reg <= 2'h0;
        end else begin
            bclk_reg <= i_backplane_bit_clock;
            fall_reg <= {fall_reg[6:0], bclk_reg & ~i_backplane_bit_clock};
            hi_reg <= o_control_status_out_enable ? hi_reg + 12'h001 : 12'h000;
            lo_reg <= o_control_status_out_enable ? 12'h000 : lo_reg + 12'h001;
            if ($fell(o_control_status_out_enable) && seen_reg != 2'h3) begin
                seen_reg <= seen_reg + 2'h1;
            end
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    AST_RESET_QUIET: assert property ($rose(i_nrst) |->
        !o_control_status_out_stream && !o_control_status_out_enable && o_ts0_ready)
        else $error("outputs not quiet out of reset");
    AST_IDLE_ZERO: assert property (!o_control_status_out_enable |-> !o_control_status_out_stream)
        else $error("stream driven outside its slots");
    AST_BIT_TIMING: assert property (($changed(o_control_status_out_stream)
        || $changed(o_control_status_out_enable)) |-> fall_reg[7:1] != 7'h00)
        else $error("stream changed away from a bit clock fall");
    AST_HIGH_SPAN: assert property ($fell(o_control_status_out_enable) |->
        hi_reg >= HI_MIN && hi_reg <= HI_MAX)
        else $error("slot window not six channels long");
    AST_LOW_SPAN: assert property ($rose(o_control_status_out_enable) && seen_reg >= 2'h2 |->
        lo_reg >= LO_MIN && lo_reg <= LO_MAX)
        else $error("slot window not once per frame");
    AST_FRAME_GAP: assert property (!i_backplane_frame_n |-> !o_control_status_out_enable)
        else $error("slot window open at frame start");
    AST_FULL_AFTER_TAKE: assert property ($fell(o_ts0_ready) |-> $past(i_ts0_valid))
        else $error("buffer went full without a word offered");
    AST_READY_RETURNS: assert property ($fell(o_ts0_ready) |-> ##[1:300] o_ts0_ready)
        else $error("buffer never drained");

    cover property ($rose(o_control_status_out_enable));
    cover property ($fell(o_ts0_ready));
    cover property (o_control_status_out_enable && o_control_status_out_stream);
endmodule

bind ersr_status_reporter ersr_status_checker u_checker (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_backplane_bit_clock(i_backplane_bit_clock), .i_backplane_frame_n(i_backplane_frame_n),
    .i_ts0_valid(i_ts0_valid), .o_ts0_ready(o_ts0_ready),
    .o_control_status_out_stream(o_control_status_out_stream),
    .o_control_status_out_enable(o_control_status_out_enable));

`default_nettype wire

// File: ersr_status_reporter.sv
// Operation
// (R1) Align byte: bit 7 is international bit, bits 6-0 received pattern bits.
// (R2) Nonalign byte: bit 7 international bit, bit 6 the nonalign marker bit.
// (R3) Nonalign byte bit 5 carries the remote alarm bit, one means alarm.
// (R4) Nonalign byte bits 4-0 carry the national bits 4 to 8.
// (R5) Master one bit 7 is one while frame alignment is lost.
// (R6) Master one bit 6 is one while multiframe sync is lost.
// (R7) Master one bit 5 toggles after 16 alignment errors, at most once per 128 ms.
// (R8) Master one bit 4 toggles on every slip.
// (R9) Master one bit 3 follows the all-ones line alarm.
// (R10) Master one bit 2 follows all ones in timeslot 16.
// (R11) External status pin sampled once per frame into master one bit 1.
// (R12) Phase byte gives timeslot count in bits 7-3, bit position in 2-0.
// (R13) 8-bit CRC error counter wraps; cleared each second when maintenance enabled.
// (R14) Master two bits 7,6 hold Si of frames 15,13, refreshed per multiframe.
// (R15) Master two bit 3 high 8 ms, falls at each one-second interval start.
// (R16) Master two bit 2 set when CRC sync missing 8 ms after frame sync; here set only while i_maintenance_enable is high.
// (R17) Master two bit 1 reads zero once CRC multiframe alignment is found.
// (R18) Master two bit 0 is ninth phase bit, toggling on phase wrap.
// (R19) CRC error counting always runs, independent of transmit CRC generation.
// (R20) Status bytes shift out MSB first in their channel slots every frame.
`timescale 1ns/1ps
`default_nettype none

module ersr_status_reporter #(
    parameter int P_SECOND_CYCLES = ersr_pkg::SECOND_CYCLES,
    parameter int P_ERR_HOLDOFF_CYCLES = ersr_pkg::ERR_HOLDOFF_CYCLES,
    parameter int P_MARK_HIGH_CYCLES = ersr_pkg::MARK_HIGH_CYCLES,
    parameter int P_CRC_TIMEOUT_CYCLES = ersr_pkg::CRC_TIMEOUT_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_nrst,
    input wire logic i_backplane_bit_clock,
    input wire logic i_backplane_frame_n,
    input wire logic i_external_status_input,
    input wire logic i_ts0_valid,
    input wire logic i_ts0_is_align,
    input wire logic [7:0] i_ts0_byte,
    output logic o_ts0_ready,
    input wire logic i_frame_sync_lost,
    input wire logic i_multiframe_sync_lost,
    input wire logic i_align_error,
    input wire logic i_slip,
    input wire logic i_rx_all_ones_alarm,
    input wire logic i_ts16_all_ones_alarm,
    input wire logic [4:0] i_tx_timeslot_count,
    input wire logic [2:0] i_tx_bit_count,
    input wire logic i_rx_multiframe_pulse,
    input wire logic i_intl_bit_frame15,
    input wire logic i_intl_bit_frame13,
    input wire logic i_crc_error,
    input wire logic i_crc_multiframe_found,
    input wire logic i_maintenance_enable,
    output logic o_control_status_out_stream,
    output logic o_control_status_out_enable
);

    localparam int TW = ersr_pkg::TIMER_W;

    typedef struct packed {
        logic [2:0] bclk_sync;
        logic [2:0] frame_sync;
        logic [2:0] xs_sync;
        logic bclk_lvl;
        logic frame_lvl;
        logic xs_lvl;
        logic [ersr_pkg::FRAME_POS_W-1:0] frame_pos;
        logic [7:0] shifter;
        logic out_bit;
        logic out_en;
        logic [7:0] align_word;
        logic [7:0] nonalign_word;
        logic ext_status;
        logic err_bit;
        logic [ersr_pkg::ERR_CNT_W-1:0] err_cnt;
        logic [TW-1:0] err_hold;
        logic slip_bit;
        logic si15;
        logic si13;
        logic [7:0] crc_cnt;
        logic [TW-1:0] sec_cnt;
        logic [TW-1:0] crc_to_cnt;
        logic crc_to_armed;
        logic crc_to_bit;
        logic fsl_prev;
        logic [7:0] phase_prev;
        logic phase_msb;
    } ersr_state_t;

    ersr_state_t st_reg;
    ersr_state_t st_next;

    logic buf_out_valid;
    logic [ersr_pkg::TS0_W-1:0] buf_out_data;
    logic buf_out_ready;
    logic buf_in_ready;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // a synchronised pin has changed once the second and third stages agree
    function automatic logic pin_changed(input logic [2:0] sync, input logic lvl);
        pin_changed = (sync[1] == sync[2]) && (sync[2] != lvl);
    endfunction

    // assemble the status byte for one stream channel
    function automatic logic [8:0] slot_byte(input ersr_state_t s, input logic [4:0] chan,
                                             input logic [7:0] m1, input logic [7:0] m2,
                                             input logic [7:0] ph);
        slot_byte = {1'b1, ersr_pkg::BYTE_RESET};
        unique case (chan)
            ersr_pkg::CH_ALIGN_WORD: slot_byte = {1'b1, s.align_word};
            ersr_pkg::CH_NONALIGN_WORD: slot_byte = {1'b1, s.nonalign_word};
            ersr_pkg::CH_MASTER_ONE: slot_byte = {1'b1, m1};
            ersr_pkg::CH_PHASE_WORD: slot_byte = {1'b1, ph};
            ersr_pkg::CH_CRC_COUNT: slot_byte = {1'b1, s.crc_cnt};
            ersr_pkg::CH_MASTER_TWO: slot_byte = {1'b1, m2};
            default: slot_byte = {1'b0, ersr_pkg::BYTE_RESET};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // timeslot 0 buffer; drained only outside the channels that publish it

    assign buf_out_ready = (st_reg.frame_pos[7:4] != ersr_pkg::TS0_WINDOW_NIBBLE);

    ersr_pair_buffer #(
        .WIDTH(ersr_pkg::TS0_W),
        .DEPTH(2)
    ) u_ts0_buffer (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_in_valid(i_ts0_valid),
        .i_in_data({i_ts0_is_align, i_ts0_byte}),
        .o_in_ready(buf_in_ready),
        .o_out_valid(buf_out_valid),
        .o_out_data(buf_out_data),
        .i_out_ready(buf_out_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [7:0] master_one;
        logic [7:0] master_two;
        logic [7:0] phase_word;
        logic [8:0] slot;
        logic bclk_fall;
        logic frame_start;
        logic sec_wrap;
        logic err_fire;
        master_one = '0;
        master_two = '0;
        phase_word = '0;
        slot = '0;
        bclk_fall = 1'b0;
        frame_start = 1'b0;
        sec_wrap = 1'b0;
        err_fire = 1'b0;
        st_next = st_reg;

        // pin synchronisers
        st_next.bclk_sync = {st_reg.bclk_sync[1:0], i_backplane_bit_clock};
        st_next.frame_sync = {st_reg.frame_sync[1:0], i_backplane_frame_n};
        st_next.xs_sync = {st_reg.xs_sync[1:0], i_external_status_input};
        if (pin_changed(st_reg.bclk_sync, st_reg.bclk_lvl)) begin
            st_next.bclk_lvl = st_reg.bclk_sync[2];
            bclk_fall = !st_reg.bclk_sync[2];
        end
        if (pin_changed(st_reg.frame_sync, st_reg.frame_lvl)) begin
            st_next.frame_lvl = st_reg.frame_sync[2];
        end
        if (pin_changed(st_reg.xs_sync, st_reg.xs_lvl)) begin
            st_next.xs_lvl = st_reg.xs_sync[2];
        end
        frame_start = bclk_fall && !st_reg.frame_lvl;

        // drain timeslot 0 words into the align or nonalign byte
        if (buf_out_valid && buf_out_ready) begin
            if (buf_out_data[ersr_pkg::TS0_KIND_BIT]) begin
                st_next.align_word = buf_out_data[7:0]; // R1
            end else begin
                st_next.nonalign_word = buf_out_data[7:0]; // R2 R3 R4
            end
        end

        // external status pin, once per frame
        if (frame_start) begin
            st_next.ext_status = st_reg.xs_lvl; // R11
        end

        // alignment errors: toggle on 16, hold off 128 ms between toggles
        if (st_reg.err_hold != '0) begin
            st_next.err_hold = st_reg.err_hold - 1'b1;
        end
        err_fire = (st_reg.err_cnt >= ersr_pkg::ERR_THRESHOLD) && (st_reg.err_hold == '0);
        if (err_fire) begin
            st_next.err_bit = !st_reg.err_bit; // R7
            st_next.err_hold = TW'(P_ERR_HOLDOFF_CYCLES - 1); // R7
            st_next.err_cnt = ersr_pkg::ERR_CNT_W'(i_align_error);
        end else if (i_align_error && (st_reg.err_cnt < ersr_pkg::ERR_THRESHOLD)) begin
            st_next.err_cnt = st_reg.err_cnt + 1'b1;
        end

        // slips
        if (i_slip) begin
            st_next.slip_bit = !st_reg.slip_bit; // R8
        end

        // Si bits per multiframe
        if (i_rx_multiframe_pulse) begin
            st_next.si15 = i_intl_bit_frame15; // R14
            st_next.si13 = i_intl_bit_frame13; // R14
        end

        // one-second interval
        sec_wrap = (st_reg.sec_cnt == TW'(P_SECOND_CYCLES - 1));
        st_next.sec_cnt = sec_wrap ? '0 : st_reg.sec_cnt + 1'b1;

        // CRC error counter; an error in the clearing cycle still counts
        if (sec_wrap && i_maintenance_enable) begin
            st_next.crc_cnt = {7'h00, i_crc_error}; // R13
        end else if (i_crc_error) begin
            st_next.crc_cnt = st_reg.crc_cnt + 1'b1; // R13 R19
        end

        // CRC sync timeout from regained frame sync
        st_next.fsl_prev = i_frame_sync_lost;
        if (st_reg.fsl_prev && !i_frame_sync_lost) begin
            st_next.crc_to_armed = 1'b1;
            st_next.crc_to_cnt = TW'(P_CRC_TIMEOUT_CYCLES - 1);
        end else if (i_frame_sync_lost || i_crc_multiframe_found) begin
            st_next.crc_to_armed = 1'b0;
        end else if (st_reg.crc_to_armed) begin
            if (st_reg.crc_to_cnt == '0) begin
                st_next.crc_to_armed = 1'b0;
                st_next.crc_to_bit = i_maintenance_enable; // R16
            end else begin
                st_next.crc_to_cnt = st_reg.crc_to_cnt - 1'b1;
            end
        end
        if (i_crc_multiframe_found || !i_maintenance_enable) begin
            st_next.crc_to_bit = 1'b0; // R16
        end

        // ninth phase bit toggles on wrap either way
        phase_word = {i_tx_timeslot_count, i_tx_bit_count}; // R12
        st_next.phase_prev = phase_word;
        if ((st_reg.phase_prev == ersr_pkg::PHASE_TOP && phase_word == ersr_pkg::PHASE_BOTTOM) ||
            (st_reg.phase_prev == ersr_pkg::PHASE_BOTTOM && phase_word == ersr_pkg::PHASE_TOP)) begin
            st_next.phase_msb = !st_reg.phase_msb; // R18
        end

        // status bytes
        master_one = {i_frame_sync_lost, // R5
                      i_multiframe_sync_lost, // R6
                      st_reg.err_bit, st_reg.slip_bit,
                      i_rx_all_ones_alarm, // R9
                      i_ts16_all_ones_alarm, // R10
                      st_reg.ext_status, ersr_pkg::UNUSED_BIT};
        master_two = {st_reg.si15, st_reg.si13, ersr_pkg::UNUSED_BIT, ersr_pkg::UNUSED_BIT,
                      (st_reg.sec_cnt >= TW'(P_SECOND_CYCLES - P_MARK_HIGH_CYCLES)), // R15
                      st_reg.crc_to_bit,
                      !i_crc_multiframe_found, // R17
                      st_reg.phase_msb};

        // serialiser: advance on each falling backplane clock edge
        if (bclk_fall) begin
            st_next.frame_pos = frame_start ? ersr_pkg::FRAME_POS_FIRST : st_reg.frame_pos + 1'b1;
            if (st_next.frame_pos[2:0] == ersr_pkg::BIT_FIRST) begin
                slot = slot_byte(st_reg, st_next.frame_pos[ersr_pkg::CHAN_MSB:ersr_pkg::CHAN_LSB],
                                 master_one, master_two, phase_word);
                st_next.shifter = {slot[6:0], 1'b0}; // R20
                st_next.out_bit = slot[7]; // R20
                st_next.out_en = slot[8];
            end else begin
                st_next.shifter = {st_reg.shifter[6:0], 1'b0};
                st_next.out_bit = st_reg.shifter[7]; // R20
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_reg <= '0;
            st_reg.bclk_sync <= 3'h7;
            st_reg.frame_sync <= 3'h7;
            st_reg.bclk_lvl <= 1'b1;
            st_reg.frame_lvl <= 1'b1;
            st_reg.align_word <= ersr_pkg::ALIGN_IDLE;
            st_reg.nonalign_word <= ersr_pkg::ALIGN_IDLE;
            st_reg.fsl_prev <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // ready is registered inside the buffer
    assign o_ts0_ready = buf_in_ready;
    assign o_control_status_out_stream = st_reg.out_bit;
    assign o_control_status_out_enable = st_reg.out_en;

endmodule

`default_nettype wire

// File: ersr_status_reporter_test.sv
`timescale 1ns/1ps
`default_nettype none

module ersr_status_reporter_test;
    logic clock, rst_n, bclk, fr_n, xs, tv, tk, rdy, fsl, mfsl, aerr, slip, ais, t16, mfp;
    logic si15, si13, cerr, cfound, maint, so, soe, errt, slipt, pmsb, mexp;
    logic [7:0] tb, aw, nw, cc;
    logic [4:0] tsc;
    logic [2:0] btc;
    logic [31:0] r;
    int n_errors, checked, seed, i, k, cyc;

    ersr_status_reporter #(.P_SECOND_CYCLES(2000), .P_ERR_HOLDOFF_CYCLES(300), .P_MARK_HIGH_CYCLES(100),
        .P_CRC_TIMEOUT_CYCLES(100)) dut (.i_clock(clock), .i_nrst(rst_n), .i_backplane_bit_clock(bclk),
        .i_backplane_frame_n(fr_n), .i_external_status_input(xs), .i_ts0_valid(tv), .i_ts0_is_align(tk),
        .i_ts0_byte(tb), .o_ts0_ready(rdy), .i_frame_sync_lost(fsl), .i_multiframe_sync_lost(mfsl),
        .i_align_error(aerr), .i_slip(slip), .i_rx_all_ones_alarm(ais), .i_ts16_all_ones_alarm(t16),
        .i_tx_timeslot_count(tsc), .i_tx_bit_count(btc), .i_rx_multiframe_pulse(mfp),
        .i_intl_bit_frame15(si15), .i_intl_bit_frame13(si13), .i_crc_error(cerr),
        .i_crc_multiframe_found(cfound), .i_maintenance_enable(maint),
        .o_control_status_out_stream(so), .o_control_status_out_enable(soe));
    ersr_stream_reader partner (.o_bit_clock(bclk), .o_frame_n(fr_n), .i_stream(so), .i_enable(soe));

    // 25 MHz system clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // cycles since reset release, in step with the one-second count
    always @(posedge clock) begin
        cyc <= rst_n ? cyc + 1 : 0;
    end

    // marker expected in channel 21: the slot is built three cycles after the bit clock fall that opens it
    always @(negedge bclk) begin
        #1;
        if (partner.pos == 168) begin
            mexp = ((cyc + 3) % 2000) >= 1900;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("counts: %0d checked, %0d wrong", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // two frame ends (channel 21 captures) pass, so every slot shows the latest state
    task automatic settle();
        int f;
        f = partner.frames;
        wait (partner.frames >= f + 2);
        @(negedge clock);
    endtask

    task automatic push(input logic kind, input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clock);
        tv = 1'b1;
        tk = kind;
        tb = b;
        while (rdy !== 1'b1 && n < 500) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        tv = 1'b0;
        if (n >= 500) begin
            n_errors++;
        end
    endtask

    task automatic pulse(input int w, input int n);
        repeat (n) begin
            @(negedge clock);
            case (w)
                0: aerr = 1'b1;
                1: slip = 1'b1;
                2: cerr = 1'b1;
                default: mfp = 1'b1;
            endcase
            @(negedge clock);
            {aerr, slip, cerr, mfp} = 4'h0;
        end
    endtask

    task automatic chk_m1();
        chk(partner.cap[18], {fsl, mfsl, errt, slipt, ais, t16, xs, 1'b0}, "master one");
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog at about 30 frames, above the roughly 22 frames of tests
    initial begin
        #3800000;
        n_errors++;
        wrap_up();
    end

    // main sequence
    initial begin
        seed = 97;
        n_errors = 0;
        checked = 0;
        rst_n = 1'b0;
        {xs, tv, tk, fsl, mfsl, aerr, slip, ais, t16, mfp, si15, si13, cerr, cfound, maint} = 15'h0000;
        {errt, slipt, pmsb} = 3'h0;
        tb = 8'h00;
        {tsc, btc} = 8'h00;
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        settle();
        @(posedge soe);
        @(negedge clock);
        aw = $random(seed);
        nw = $random(seed);
        push(1'b1, aw);
        push(1'b0, nw);
        chk({7'h00, rdy}, 8'h00, "ready with two words held");
        aw = {aw[7], 7'h1B};
        push(1'b1, aw);
        settle();
        chk(partner.cap[16], aw, "align word");
        chk(partner.cap[17], nw, "nonalign word");
        $display("test ts0 words done");
        for (i = 0; i < 2; i++) begin
            r = $random(seed);
            {fsl, mfsl, ais, t16, xs} = r[4:0];
            k = r[6:5];
            pulse(1, k);
            slipt ^= r[5];
            settle();
            chk_m1();
        end
        pulse(0, 15);
        settle();
        chk_m1();
        pulse(0, 1);
        errt = ~errt;
        settle();
        chk_m1();
        $display("test master one done");
        r = $random(seed);
        {tsc, btc} = {1'b0, r[6:0]} | 8'h01;
        {si15, si13, cfound} = r[10:8];
        pulse(3, 1);
        settle();
        chk(partner.cap[19], {tsc, btc}, "phase word");
        {tsc, btc} = 8'hFF;
        @(negedge clock);
        {tsc, btc} = 8'h00;
        pmsb = ~pmsb;
        settle();
        chk(partner.cap[21], {si15, si13, 2'h0, mexp, 1'b0, ~cfound, pmsb}, "master two");
        $display("test phase and master two done");
        k = 256 + r[15:12];
        pulse(2, k);
        cc = k[7:0];
        settle();
        chk(partner.cap[20], cc, "crc count wraps");
        fsl = 1'b1;
        maint = 1'b1;
        cfound = 1'b0;
        @(negedge clock);
        fsl = 1'b0;
        settle();
        chk(partner.cap[20], 8'h00, "crc count cleared");
        chk(partner.cap[21] & 8'h06, 8'h06, "crc timeout set");
        cfound = 1'b1;
        settle();
        chk(partner.cap[21] & 8'h06, 8'h00, "crc timeout cleared");
        chk({7'h00, partner.n_bad != 0}, 8'h00, "slot enable placement");
        $display("test crc done");
        wrap_up();
    end
endmodule

`default_nettype wire

// File: ersr_stream_reader.sv
`timescale 1ns/1ps
`default_nettype none

// controller side: free-running backplane clock and frame pulse, captures the status slots
module ersr_stream_reader (
    output logic o_bit_clock,
    output logic o_frame_n,
    input wire logic i_stream,
    input wire logic i_enable
);
    logic [7:0] cap [0:31];
    logic [7:0] sh;
    int pos;
    int frames;
    int n_bad;

    // a bit is sampled at the falling edge after the one that launched it
    initial begin
        o_bit_clock = 1'b1;
        o_frame_n = 1'b1;
        sh = 8'h00;
        pos = 255;
        frames = 0;
        n_bad = 0;
        #2; // keeps bit clock edges clear of the system clock edges
        forever begin
            #244;
            o_bit_clock = 1'b0;
            sh = {sh[6:0], i_stream};
            if (frames > 0 && i_enable !== ((pos >> 3) >= 16 && (pos >> 3) <= 21)) begin
                n_bad++;
            end
            if ((pos & 7) == 7) begin
                cap[pos >> 3] = sh;
                if ((pos >> 3) == 21) begin
                    frames++;
                end
            end
            pos = (pos + 1) % 256;
            #244;
            o_bit_clock = 1'b1;
            o_frame_n = (pos != 255);
        end
    end
endmodule

`default_nettype wire
